// ### exec_consts.vh
// Purpose: Constants for the bit, decimal and flow execution unit
// Assumes: One clock, synchronous active-high reset
// Notes: Operation, condition and state codes plus stack step sizes
`ifndef EXEC_CONSTS_VH
`define EXEC_CONSTS_VH
`define OP_BIT_TEST 5'h00
`define OP_BIT_TEST_SET 5'h01
`define OP_BIT_TEST_CLEAR 5'h02
`define OP_BIT_TEST_INVERT 5'h03
`define OP_DECIMAL_ADD_EXT 5'h04
`define OP_DECIMAL_SUB_EXT 5'h05
`define OP_DECIMAL_NEGATE_EXT 5'h06
`define OP_COND_BRANCH 5'h07
`define OP_ALWAYS_BRANCH 5'h08
`define OP_LOOP_COUNT_BRANCH 5'h09
`define OP_COND_SET 5'h0A
`define OP_REL_SUB_CALL 5'h0B
`define OP_ABS_JUMP 5'h0C
`define OP_ABS_SUB_CALL 5'h0D
`define OP_NO_OPERATION 5'h0E
`define OP_RETURN 5'h0F
`define OP_RETURN_DEALLOC 5'h10
`define OP_RETURN_RESTORE_FLAGS 5'h11
`define CC_T 4'h0
`define CC_F 4'h1
`define CC_HI 4'h2
`define CC_LS 4'h3
`define CC_CC 4'h4
`define CC_CS 4'h5
`define CC_NE 4'h6
`define CC_EQ 4'h7
`define CC_VC 4'h8
`define CC_VS 4'h9
`define CC_PL 4'hA
`define CC_MI 4'hB
`define CC_GE 4'hC
`define CC_LT 4'hD
`define CC_GT 4'hE
`define CC_LE 4'hF
`define FLAG_C 0
`define FLAG_V 1
`define FLAG_Z 2
`define FLAG_N 3
`define FLAG_X 4
`define STEP_LONG 32'h00000004
`define STEP_WORD 32'h00000002
`define STEP_NOP 32'h00000002
`define LOOP_END 16'hFFFF
`define ST_IDLE 3'h0
`define ST_RD_FLAGS 3'h1
`define ST_RD_PC 3'h2
`define ST_WR_PC 3'h3
`define ST_DONE 3'h4
`endif

// ### decimal_unit.v
// Purpose: Packed decimal add and subtract of one byte with extend in
// Assumes: Operands hold valid decimal digits
// Notes: Purely combinational; negate is subtract from zero
`timescale 1ns/1ns
module decimal_unit (
  input wire [7:0] a,          // Minuend or addend
  input wire [7:0] b,          // Subtrahend or addend
  input wire ext,              // Extend flag in
  input wire sub,              // High selects a - b - ext
  output reg [7:0] result,     // Decimal result byte
  output reg carry             // Decimal carry or borrow
);
  reg [4:0] lo;
  reg [4:0] hi;
  reg lo_c;
  always @* begin
    lo = 5'h00;
    hi = 5'h00;
    lo_c = 1'b0;
    result = 8'h00;
    carry = 1'b0;
    if (sub) begin
      lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ext};
      lo_c = lo[4];
      if (lo_c) lo = lo - 5'h06;
      hi = {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, lo_c};
      carry = hi[4];
      if (carry) hi = hi - 5'h06;
    end else begin
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ext};
      lo_c = (lo > 5'h09);
      if (lo_c) lo = lo + 5'h06;
      hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo_c};
      carry = (hi > 5'h09);
      if (carry) hi = hi + 5'h06;
    end
    result = {hi[3:0], lo[3:0]};
  end
endmodule

// ### bit_bcd_branch_exec.v
// Purpose: Executes bit, packed decimal and program flow operations
// Assumes: Sequencer supplies operands; stack memory answers reads with valid
// Notes: One operation per START; DONE pulses when results are posted
//
// Behaviour
// - Four bit operations on register or memory
// - Bit number immediate or from data register
// - Register operand 32 bits, memory 8
// - Bit test: zero flag gets inverted bit
// - Test-set: flag then write one
// - Test-clear: flag then write zero
// - Test-invert: flag then flip bit
// - Decimal add source, destination, extend
// - Decimal subtract destination minus source minus extend
// - Decimal negate zero minus destination minus extend
// - Conditional branch adds displacement when true
// - Loop branch on false condition decrements low word, stops at minus one
// - Conditional set writes low byte all ones or zeros
// - Relative call pushes return, adds displacement
// - Absolute call pushes return, loads address
// - No operation advances counter by two
// - Return pops counter, stack up four
// - Return-dealloc adds four plus signed displacement
// - Return-restore pops flags then counter
// - Condition field selects one of sixteen tests
// - Always-false not allowed on conditional branch
`timescale 1ns/1ns
`include "exec_consts.vh"
module bit_bcd_branch_exec (
  input wire CLOCK,              // System clock
  input wire RST,                // Synchronous reset, active high
  input wire START,              // One-cycle pulse starting an operation
  input wire [4:0] OPCODE,       // Operation select
  input wire [3:0] COND,         // Condition field
  input wire MEM_OPERAND,        // High when operand is a memory byte
  input wire BIT_FROM_REG,       // High when bit number comes from data_reg
  input wire [7:0] BIT_IMM,      // Immediate bit number
  input wire [31:0] DATA_REG_IN, // data_reg holding the bit number
  input wire [31:0] DEST_IN,     // Destination operand
  input wire [7:0] SRC_IN,       // Decimal source byte
  input wire [31:0] DISP,        // Sign-extended displacement
  input wire [31:0] EA,          // Computed effective address
  input wire [31:0] PC_IN,       // Program counter of this instruction
  input wire [31:0] RET_PC,      // Return address to push
  input wire [31:0] SP_IN,       // Stack pointer
  input wire [4:0] FLAGS_IN,     // flag_register X N Z V C
  input wire [31:0] MEM_RDATA,   // Stack read data
  input wire MEM_RVALID,         // Stack read data valid
  output reg [31:0] RESULT,      // Destination write value
  output reg RESULT_WE,          // Destination write enable
  output reg [31:0] PC_OUT,      // New program counter
  output reg [31:0] SP_OUT,      // New stack pointer
  output reg SP_WE,              // Stack pointer write enable
  output reg [4:0] FLAGS_OUT,    // New flag_register value
  output reg MEM_RD,             // Stack read strobe
  output reg MEM_WR,             // Stack write strobe
  output reg MEM_WORD,           // Stack access is 16 bits
  output reg [31:0] MEM_ADDR,    // Stack address
  output reg [31:0] MEM_WDATA,   // Stack write data
  output reg ILLEGAL,            // Conditional branch used always-false, or unknown opcode
  output reg BUSY,               // Operation in progress
  output reg DONE                // One-cycle pulse: outputs valid
);
  reg [2:0] state;
  reg [4:0] op;
  reg [31:0] sp;
  reg [31:0] disp;
  reg [4:0] bitnum;
  reg bit_val;
  reg [31:0] bit_mask;
  reg cond_true;
  wire [7:0] dec_a;
  wire [7:0] dec_b;
  wire dec_sub;
  wire [7:0] dec_res;
  wire dec_carry;
  wire [15:0] count_next;
  wire c = FLAGS_IN[`FLAG_C];
  wire v = FLAGS_IN[`FLAG_V];
  wire z = FLAGS_IN[`FLAG_Z];
  wire n = FLAGS_IN[`FLAG_N];

  // Bit number from immediate or register, reduced by operand width
  always @* begin
    if (BIT_FROM_REG)
      bitnum = DATA_REG_IN[4:0];
    else
      bitnum = BIT_IMM[4:0];
    if (MEM_OPERAND)
      bitnum = {2'b00, bitnum[2:0]};
    bit_val = DEST_IN[bitnum];
    bit_mask = 32'h00000001 << bitnum;
  end

  always @* begin
    case (COND)
      `CC_T: cond_true = 1'b1;
      `CC_F: cond_true = 1'b0;
      `CC_HI: cond_true = ~c & ~z;
      `CC_LS: cond_true = c | z;
      `CC_CC: cond_true = ~c;
      `CC_CS: cond_true = c;
      `CC_NE: cond_true = ~z;
      `CC_EQ: cond_true = z;
      `CC_VC: cond_true = ~v;
      `CC_VS: cond_true = v;
      `CC_PL: cond_true = ~n;
      `CC_MI: cond_true = n;
      `CC_GE: cond_true = ~(n ^ v);
      `CC_LT: cond_true = n ^ v;
      `CC_GT: cond_true = ~z & ~(n ^ v);
      `CC_LE: cond_true = z | (n ^ v);
      default: cond_true = 1'b0;
    endcase
  end

  assign dec_sub = (OPCODE != `OP_DECIMAL_ADD_EXT);
  assign dec_a = (OPCODE == `OP_DECIMAL_NEGATE_EXT) ? 8'h00 : DEST_IN[7:0];
  assign dec_b = (OPCODE == `OP_DECIMAL_NEGATE_EXT) ? DEST_IN[7:0] : SRC_IN;
  assign count_next = DEST_IN[15:0] - 16'h0001;

  decimal_unit dec (
    .a(dec_a),
    .b(dec_b),
    .ext(FLAGS_IN[`FLAG_X]),
    .sub(dec_sub),
    .result(dec_res),
    .carry(dec_carry)
  );

  always @(posedge CLOCK) begin
    if (RST) begin
      state <= `ST_IDLE;
      op <= 5'h00;
      sp <= 32'h00000000;
      disp <= 32'h00000000;
      RESULT <= 32'h00000000;
      RESULT_WE <= 1'b0;
      PC_OUT <= 32'h00000000;
      SP_OUT <= 32'h00000000;
      SP_WE <= 1'b0;
      FLAGS_OUT <= 5'h00;
      MEM_RD <= 1'b0;
      MEM_WR <= 1'b0;
      MEM_WORD <= 1'b0;
      MEM_ADDR <= 32'h00000000;
      MEM_WDATA <= 32'h00000000;
      ILLEGAL <= 1'b0;
      BUSY <= 1'b0;
      DONE <= 1'b0;
    end else begin
      DONE <= 1'b0;
      MEM_RD <= 1'b0;
      MEM_WR <= 1'b0;
      case (state)
        `ST_IDLE: begin
          if (START) begin
            op <= OPCODE;
            disp <= DISP;
            sp <= SP_IN;
            RESULT <= DEST_IN;
            RESULT_WE <= 1'b0;
            SP_WE <= 1'b0;
            ILLEGAL <= 1'b0;
            FLAGS_OUT <= FLAGS_IN;
            PC_OUT <= PC_IN;
            SP_OUT <= SP_IN;
            MEM_WORD <= 1'b0;
            BUSY <= 1'b1;
            state <= `ST_DONE;
            case (OPCODE)
              `OP_BIT_TEST: begin
                FLAGS_OUT[`FLAG_Z] <= ~bit_val;
              end
              `OP_BIT_TEST_SET: begin
                FLAGS_OUT[`FLAG_Z] <= ~bit_val;
                RESULT <= DEST_IN | bit_mask;
                RESULT_WE <= 1'b1;
              end
              `OP_BIT_TEST_CLEAR: begin
                FLAGS_OUT[`FLAG_Z] <= ~bit_val;
                RESULT <= DEST_IN & ~bit_mask;
                RESULT_WE <= 1'b1;
              end
              `OP_BIT_TEST_INVERT: begin
                FLAGS_OUT[`FLAG_Z] <= ~bit_val;
                RESULT <= DEST_IN ^ bit_mask;
                RESULT_WE <= 1'b1;
              end
              `OP_DECIMAL_ADD_EXT, `OP_DECIMAL_SUB_EXT, `OP_DECIMAL_NEGATE_EXT: begin
                RESULT <= {DEST_IN[31:8], dec_res};
                RESULT_WE <= 1'b1;
                FLAGS_OUT[`FLAG_C] <= dec_carry;
                FLAGS_OUT[`FLAG_X] <= dec_carry;
                if (dec_res != 8'h00)
                  FLAGS_OUT[`FLAG_Z] <= 1'b0;
              end
              `OP_COND_BRANCH: begin
                if (COND == `CC_F)
                  ILLEGAL <= 1'b1;
                else if (cond_true)
                  PC_OUT <= PC_IN + DISP;
              end
              `OP_ALWAYS_BRANCH: PC_OUT <= PC_IN + DISP;
              `OP_LOOP_COUNT_BRANCH: begin
                if (!cond_true) begin
                  RESULT <= {DEST_IN[31:16], count_next};
                  RESULT_WE <= 1'b1;
                  if (count_next != `LOOP_END)
                    PC_OUT <= PC_IN + DISP;
                end
              end
              `OP_COND_SET: begin
                RESULT <= {DEST_IN[31:8], cond_true ? 8'hFF : 8'h00};
                RESULT_WE <= 1'b1;
              end
              `OP_ABS_JUMP: PC_OUT <= EA;
              `OP_REL_SUB_CALL, `OP_ABS_SUB_CALL: begin
                SP_OUT <= SP_IN - `STEP_LONG;
                SP_WE <= 1'b1;
                MEM_ADDR <= SP_IN - `STEP_LONG;
                MEM_WDATA <= RET_PC;
                MEM_WR <= 1'b1;
                if (OPCODE == `OP_REL_SUB_CALL)
                  PC_OUT <= PC_IN + DISP;
                else
                  PC_OUT <= EA;
                state <= `ST_WR_PC;
              end
              `OP_NO_OPERATION: PC_OUT <= PC_IN + `STEP_NOP;
              `OP_RETURN, `OP_RETURN_DEALLOC: begin
                MEM_ADDR <= SP_IN;
                MEM_RD <= 1'b1;
                state <= `ST_RD_PC;
              end
              `OP_RETURN_RESTORE_FLAGS: begin
                MEM_ADDR <= SP_IN;
                MEM_WORD <= 1'b1;
                MEM_RD <= 1'b1;
                state <= `ST_RD_FLAGS;
              end
              default: ILLEGAL <= 1'b1;
            endcase
          end
        end
        `ST_RD_FLAGS: begin
          if (MEM_RVALID) begin
            FLAGS_OUT <= MEM_RDATA[4:0];
            sp <= sp + `STEP_WORD;
            MEM_ADDR <= sp + `STEP_WORD;
            MEM_WORD <= 1'b0;
            MEM_RD <= 1'b1;
            state <= `ST_RD_PC;
          end
        end
        `ST_RD_PC: begin
          if (MEM_RVALID) begin
            PC_OUT <= MEM_RDATA;
            SP_WE <= 1'b1;
            if (op == `OP_RETURN_DEALLOC)
              SP_OUT <= sp + `STEP_LONG + disp;
            else
              SP_OUT <= sp + `STEP_LONG;
            state <= `ST_DONE;
          end
        end
        `ST_WR_PC: state <= `ST_DONE;
        `ST_DONE: begin
          DONE <= 1'b1;
          BUSY <= 1'b0;
          state <= `ST_IDLE;
        end
        default: state <= `ST_IDLE;
      endcase
    end
  end
endmodule

// ### exec_checker_assertions.sv
// Purpose: Port-level timing and value checks on the execution unit
// Assumes: One clock, RST synchronous active high
// Notes: Bound onto every instance of the unit
`timescale 1ns/1ns
`include "exec_consts.vh"
module exec_checker (
  input wire CLOCK, // Clock
  input wire RST, // Reset
  input wire START, // Start pulse
  input wire [4:0] OPCODE, // Op select
  input wire [3:0] COND, // Condition
  input wire [31:0] PC_IN, // Base PC
  input wire [31:0] DISP, // Displacement
  input wire [31:0] SP_IN, // Stack pointer
  input wire [31:0] EA, // Target address
  input wire [31:0] RET_PC, // Pushed value
  input wire [31:0] PC_OUT, // New PC
  input wire [31:0] SP_OUT, // New SP
  input wire [31:0] MEM_ADDR, // Stack address
  input wire [31:0] MEM_WDATA, // Stack data
  input wire MEM_RD, // Stack read
  input wire MEM_WR, // Stack write
  input wire MEM_WORD, // Word access
  input wire ILLEGAL, // Refused op
  input wire BUSY, // Busy
  input wire DONE // Done
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  wire go = START & ~BUSY;
  AST_NOP_PC: assert property (go && OPCODE == `OP_NO_OPERATION |->
    ##2 (DONE && PC_OUT == $past(PC_IN, 2) + `STEP_NOP)) else $error("nop pc wrong");
  AST_BRA_PC: assert property (go && OPCODE == `OP_ALWAYS_BRANCH |->
    ##2 (PC_OUT == $past(PC_IN, 2) + $past(DISP, 2))) else $error("branch pc wrong");
  AST_REL_CALL: assert property (go && OPCODE == `OP_REL_SUB_CALL |=>
    (MEM_WR && MEM_ADDR == $past(SP_IN) - `STEP_LONG && SP_OUT == MEM_ADDR
    && PC_OUT == $past(PC_IN) + $past(DISP))) else $error("call push wrong");
  AST_ABS_CALL: assert property (go && OPCODE == `OP_ABS_SUB_CALL |=>
    (MEM_WR && MEM_WDATA == $past(RET_PC) && PC_OUT == $past(EA))) else $error("jsr wrong");
  AST_CALL_DONE: assert property (go && OPCODE == `OP_REL_SUB_CALL |-> ##3 DONE)
    else $error("call latency wrong");
  AST_RET_READ: assert property (go && OPCODE == `OP_RETURN |=>
    (MEM_RD && MEM_ADDR == $past(SP_IN))) else $error("return read wrong");
  AST_RTR_WORD: assert property (go && OPCODE == `OP_RETURN_RESTORE_FLAGS |=>
    (MEM_RD && MEM_WORD && MEM_ADDR == $past(SP_IN))) else $error("flag pop wrong");
  AST_COND_F: assert property (go && OPCODE == `OP_COND_BRANCH && COND == `CC_F |->
    ##2 (DONE && ILLEGAL && PC_OUT == $past(PC_IN, 2))) else $error("false branch taken");
  AST_RD_PULSE: assert property (MEM_RD |=> !MEM_RD) else $error("read held");
  cover property (go && OPCODE == `OP_RETURN_RESTORE_FLAGS);
  cover property (go && OPCODE == `OP_ABS_SUB_CALL);
  cover property (DONE && ILLEGAL);
endmodule
bind bit_bcd_branch_exec exec_checker exec_checker_inst (.CLOCK(CLOCK), .RST(RST),
  .START(START), .OPCODE(OPCODE), .COND(COND), .PC_IN(PC_IN), .DISP(DISP), .SP_IN(SP_IN),
  .EA(EA), .RET_PC(RET_PC), .PC_OUT(PC_OUT), .SP_OUT(SP_OUT), .MEM_ADDR(MEM_ADDR),
  .MEM_WDATA(MEM_WDATA), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_WORD(MEM_WORD),
  .ILLEGAL(ILLEGAL), .BUSY(BUSY), .DONE(DONE));

// ### stack_mem_model.sv
// Purpose: Stack memory answering the unit's reads and writes
// Assumes: Read answered wait_cyc + 1 cycles after the edge that samples the strobe
// Notes: Data bus toggles when no answer is driven
`timescale 1ns/1ns
module stack_mem_model (
  input wire clk, // Clock
  input wire rd, // Read strobe
  input wire wr, // Write strobe
  input wire word, // 16-bit read
  input wire [31:0] addr, // Address
  input wire [31:0] wdata, // Write data
  input wire [3:0] wait_cyc, // Answer delay
  output logic [31:0] rdata, // Read data
  output logic rvalid // Read valid
);
  // Word-granular store keyed by address bits 8..1
  logic [31:0] mem [0:255];
  logic [7:0] a;
  logic w;
  int cnt = -1;
  initial rdata = 32'h00000000;
  initial rvalid = 1'b0;
  always @(posedge clk) begin
    rvalid <= 1'b0;
    rdata <= ~rdata;
    if (wr)
      mem[addr[8:1]] <= wdata;
    if (rd) begin
      cnt <= wait_cyc;
      a <= addr[8:1];
      w <= word;
    end else if (cnt == 0) begin
      rvalid <= 1'b1;
      rdata <= w ? {16'h0000, mem[a][15:0]} : mem[a];
      cnt <= -1;
    end else if (cnt > 0)
      cnt <= cnt - 1;
  end
endmodule

// ### tb_top.sv
// Purpose: Self-checking bench for the execution unit
// Assumes: Stack model stands behind the memory port
// Notes: One task per scenario, except the branch, jump and no-operation checks, which run inline
`timescale 1ns/1ns
`include "exec_consts.vh"
module tb_top;
  logic CLOCK = 0, RST = 1, START = 0, MEM_OPERAND = 0, BIT_FROM_REG = 0;
  logic [4:0] OPCODE = 0, FLAGS_IN = 0;
  logic [3:0] COND = 0, wait_cyc = 0;
  logic [7:0] BIT_IMM = 0, SRC_IN = 0;
  logic [31:0] DATA_REG_IN = 0, DEST_IN = 0, SP_IN = 0, RET_PC = 0;
  logic [31:0] DISP = 32'hFFFFFFF0, EA = 32'h00003000, PC_IN = 32'h00001000;
  wire [31:0] RESULT, PC_OUT, SP_OUT, MEM_ADDR, MEM_WDATA, MEM_RDATA;
  wire [4:0] FLAGS_OUT;
  wire RESULT_WE, SP_WE, MEM_RD, MEM_WR, MEM_WORD, MEM_RVALID, ILLEGAL, BUSY, DONE;
  int num_errors = 0, n_tests = 0, cyc = 0;
  bit_bcd_branch_exec bit_bcd_branch_exec_inst (.CLOCK(CLOCK), .RST(RST), .START(START),
    .OPCODE(OPCODE), .COND(COND), .MEM_OPERAND(MEM_OPERAND), .BIT_FROM_REG(BIT_FROM_REG),
    .BIT_IMM(BIT_IMM), .DATA_REG_IN(DATA_REG_IN), .DEST_IN(DEST_IN), .SRC_IN(SRC_IN),
    .DISP(DISP), .EA(EA), .PC_IN(PC_IN), .RET_PC(RET_PC), .SP_IN(SP_IN), .FLAGS_IN(FLAGS_IN),
    .MEM_RDATA(MEM_RDATA), .MEM_RVALID(MEM_RVALID), .RESULT(RESULT), .RESULT_WE(RESULT_WE),
    .PC_OUT(PC_OUT), .SP_OUT(SP_OUT), .SP_WE(SP_WE), .FLAGS_OUT(FLAGS_OUT), .MEM_RD(MEM_RD),
    .MEM_WR(MEM_WR), .MEM_WORD(MEM_WORD), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
    .ILLEGAL(ILLEGAL), .BUSY(BUSY), .DONE(DONE));
  stack_mem_model stack_mem_model_inst (.clk(CLOCK), .rd(MEM_RD), .wr(MEM_WR),
    .word(MEM_WORD), .addr(MEM_ADDR), .wdata(MEM_WDATA), .wait_cyc(wait_cyc),
    .rdata(MEM_RDATA), .rvalid(MEM_RVALID));
  initial forever #2 CLOCK = ~CLOCK;
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Called just after a rising edge; returns at the falling edge of the done cycle
  task go(input logic [4:0] op);
    int i;
    OPCODE <= op;
    START <= 1'b1;
    @(posedge CLOCK);
    START <= 1'b0;
    @(negedge CLOCK);
    chk({BUSY, DONE}, 2'b10);
    for (i = 0; i < 40 && DONE !== 1'b1; i++)
      @(negedge CLOCK);
    chk({BUSY, DONE}, 2'b01);
  endtask
  // Reset in the middle of a call; every output must read zero after release
  task t_reset;
    @(posedge CLOCK);
    OPCODE <= `OP_REL_SUB_CALL;
    START <= 1'b1;
    @(posedge CLOCK);
    START <= 1'b0;
    RST <= 1'b1;
    repeat (2) @(posedge CLOCK);
    RST <= 1'b0;
    @(posedge CLOCK);
    @(negedge CLOCK);
    chk({BUSY, DONE, SP_WE, MEM_WR, MEM_RD, MEM_WORD, RESULT_WE, ILLEGAL, FLAGS_OUT}, 64'h0);
    chk({SP_OUT, PC_OUT}, 64'h0);
    chk({MEM_ADDR, MEM_WDATA}, 64'h0);
    chk(RESULT, 64'h0);
    $display("reset test done");
  endtask
  task t_bits;
    int op;
    logic [31:0] m, e;
    for (op = 0; op < 8; op++) begin
      m = op[2] ? 32'h00000008 : 32'h80000000;
      @(posedge CLOCK);
      MEM_OPERAND <= op[2];
      BIT_FROM_REG <= ~op[2];
      DATA_REG_IN <= 32'h0000003F;
      BIT_IMM <= 8'h0B;
      DEST_IN <= 32'h800000F0;
      go({3'h0, op[1:0]});
      case (op[1:0])
        0: e = 32'h800000F0;
        1: e = 32'h800000F0 | m;
        2: e = 32'h800000F0 & ~m;
        default: e = 32'h800000F0 ^ m;
      endcase
      chk(FLAGS_OUT[`FLAG_Z], op[2]);
      chk({RESULT_WE, RESULT}, {op[1:0] != 2'b00, e});
    end
    $display("bit test done");
  endtask
  task dec(input logic [4:0] op, input logic [7:0] s, input logic [7:0] d, input logic x,
    input logic [7:0] r, input logic c);
    @(posedge CLOCK);
    SRC_IN <= s;
    DEST_IN <= {24'h000000, d};
    FLAGS_IN <= {x, 4'h4};
    go(op);
    chk(RESULT[7:0], r);
    chk({FLAGS_OUT[`FLAG_X], FLAGS_OUT[`FLAG_C], FLAGS_OUT[`FLAG_Z]}, {c, c, r == 8'h00});
  endtask
  // t holds, per condition code, whether the test is true for flags f
  task t_cond(input logic [4:0] f, input logic [15:0] t);
    int c;
    for (c = 0; c < 16; c++) begin
      @(posedge CLOCK);
      COND <= c[3:0];
      FLAGS_IN <= f;
      go(`OP_COND_BRANCH);
      chk(PC_OUT, t[c] ? 32'h00000FF0 : 32'h00001000);
      chk(ILLEGAL, c == `CC_F);
      @(posedge CLOCK);
      go(`OP_COND_SET);
      chk({RESULT[7:0], ILLEGAL}, t[c] ? 9'h1FE : 9'h000);
    end
    $display("condition test done");
  endtask
  task lp(input logic [3:0] cc, input logic [31:0] d, input logic [31:0] r,
    input logic [31:0] pc, input logic we);
    @(posedge CLOCK);
    COND <= cc;
    DEST_IN <= d;
    go(`OP_LOOP_COUNT_BRANCH);
    chk({RESULT_WE, RESULT}, {we, r});
    chk(PC_OUT, pc);
  endtask
  task st(input logic [4:0] op, input logic [31:0] sp, input logic [31:0] ret,
    input logic [3:0] w, input logic [31:0] pc, input logic [31:0] spo);
    @(posedge CLOCK);
    SP_IN <= sp;
    RET_PC <= ret;
    wait_cyc <= w;
    go(op);
    chk(PC_OUT, pc);
    chk({SP_WE, SP_OUT}, {1'b1, spo});
  endtask
  initial begin
    repeat (16) @(posedge CLOCK);
    RST <= 1'b0;
    t_reset;
    t_bits;
    dec(`OP_DECIMAL_ADD_EXT, 8'h38, 8'h45, 1'b1, 8'h84, 1'b0);
    dec(`OP_DECIMAL_ADD_EXT, 8'h01, 8'h99, 1'b0, 8'h00, 1'b1);
    dec(`OP_DECIMAL_SUB_EXT, 8'h45, 8'h23, 1'b0, 8'h78, 1'b1);
    dec(`OP_DECIMAL_NEGATE_EXT, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0);
    dec(`OP_DECIMAL_NEGATE_EXT, 8'h00, 8'h01, 1'b1, 8'h98, 1'b1);
    $display("decimal test done");
    t_cond(5'h00, 16'h5555);
    t_cond(5'h0F, 16'h9AA9);
    t_cond(5'h08, 16'hA955);
    lp(`CC_F, 32'hABCD0000, 32'hABCDFFFF, 32'h00001000, 1'b1);
    lp(`CC_F, 32'h12340005, 32'h12340004, 32'h00000FF0, 1'b1);
    lp(`CC_T, 32'h12340005, 32'h12340005, 32'h00001000, 1'b0);
    @(posedge CLOCK);
    go(`OP_ALWAYS_BRANCH);
    chk(PC_OUT, 32'h00000FF0);
    @(posedge CLOCK);
    go(`OP_ABS_JUMP);
    chk({ILLEGAL, SP_WE, MEM_WR, PC_OUT}, {3'h0, 32'h00003000});
    @(posedge CLOCK);
    go(`OP_NO_OPERATION);
    chk({SP_WE, RESULT_WE, MEM_WR, PC_OUT}, {3'h0, 32'h00001002});
    $display("flow test done");
    t_reset;
    @(posedge CLOCK);
    DISP <= 32'hFFFFFFF8;
    st(`OP_REL_SUB_CALL, 32'h00002000, 32'h0000ABCE, 4'h0, 32'h00000FF8, 32'h00001FFC);
    st(`OP_ABS_SUB_CALL, 32'h00001FFC, 32'h00005678, 4'h0, 32'h00003000, 32'h00001FF8);
    st(`OP_RETURN, 32'h00001FF8, 32'h0, 4'h3, 32'h00005678, 32'h00001FFC);
    st(`OP_RETURN_DEALLOC, 32'h00001FFC, 32'h0, 4'h0, 32'h0000ABCE, 32'h00001FF8);
    st(`OP_ABS_SUB_CALL, 32'h00001FF6, 32'h00004444, 4'h0, 32'h00003000, 32'h00001FF2);
    st(`OP_ABS_SUB_CALL, 32'h00001FF4, 32'h00000013, 4'h0, 32'h00003000, 32'h00001FF0);
    st(`OP_RETURN_RESTORE_FLAGS, 32'h00001FF0, 32'h0, 4'h1, 32'h00004444, 32'h00001FF6);
    chk(FLAGS_OUT, 5'h13);
    $display("stack test done");
    report_and_stop;
  end
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      report_and_stop;
    end
  end
endmodule
